// ==== include/scds_pkg.sv ====
// Purpose: Constants and types for the serial clock divider select block
// Assumes: Avalon-MM slave with 32-bit data, byte addresses
// Notes:   Clock division codes run 0110..1101 for divide by 2..256
package scds_pkg;

    localparam int          SCDS_ADDR_W         = 16;
    localparam int          SCDS_DATA_W         = 32;
    localparam int          SCDS_NUM_CH         = 2;
    localparam int          SCDS_PRE_W          = 9;

    localparam logic [15:0] SCDS_SEL_OFFSET     = 16'hff43;
    localparam logic [15:0] SCDS_OSC_OFFSET     = 16'hff44;
    localparam logic [15:0] SCDS_SRC_OFFSET     = 16'hff48;

    localparam logic [7:0]  SCDS_SEL_RESET      = 8'h88;
    localparam logic        SCDS_OSC_RESET      = 1'b0;
    localparam logic [1:0]  SCDS_SRC_RESET      = 2'h0;

    localparam logic [3:0]  SCDS_CODE_MIN       = 4'h6;
    localparam logic [3:0]  SCDS_CODE_MAX       = 4'hd;
    localparam int          SCDS_CH0_LSB        = 0;
    localparam int          SCDS_CH1_LSB        = 4;
    localparam int          SCDS_OSC_BIT        = 0;

    localparam logic [1:0]  SCDS_SRC_EXT        = 2'h0;
    localparam logic [1:0]  SCDS_SRC_TIMER      = 2'h2;
    localparam logic [1:0]  SCDS_SRC_DIV        = 2'h3;

    typedef enum logic [1:0]
    {
        SCDS_IDLE = 2'b00,
        SCDS_ACK  = 2'b01
    } scds_bus_t;

endpackage

// ==== core/scds_divider.sv ====
// Purpose: Free running prescaler and per-channel tap selection
// Assumes: One clock, synchronous inputs
// Notes:   Taps are one-cycle enables, not clocks
`timescale 1ns/1ps
`default_nettype none
module scds_divider
#(
    parameter int PRE_W = 9
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Control
    input  wire logic             osc_full,
    input  wire logic [7:0]       sel,
    // Ticks
    output var  logic [1:0]       tick
);
    import scds_pkg::*;

    typedef struct packed
    {
        logic             half;
        logic [PRE_W-1:0] pre;
        logic [1:0]       tick;
    } scds_div_t;

    scds_div_t st_r;
    scds_div_t st_nxt;
    logic      main_en;

    // The widest tap needs eight prescaler bits plus one spare
    if (PRE_W < 9)
    begin : g_pre_w_check
        $error("PRE_W too small for divide by 256");
    end

    // Main system clock: every cycle or every other one
    assign main_en = osc_full | st_r.half;

    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.half = ~st_r.half;
        if (main_en)
            st_nxt.pre = st_r.pre + 1'b1;
        for (int c = 0; c < SCDS_NUM_CH; c++)
        begin
            logic [3:0] code;
            int         k;
            code = sel[c*4 +: 4];
            k    = int'(code) - int'(SCDS_CODE_MIN) + 1;
            st_nxt.tick[c] = 1'b0;
            // Divide by 2**k; other codes give no tick
            if (code >= SCDS_CODE_MIN && code <= SCDS_CODE_MAX && main_en)
                st_nxt.tick[c] = (st_r.pre & ((PRE_W'(1) << k) - 1'b1)) == ((PRE_W'(1) << k) - 1'b1);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign tick = st_r.tick;
endmodule
`default_nettype wire

// ==== core/scds_top.sv ====
// Purpose: Serial clock divider select register with channel clock enables
// Assumes: Avalon-MM slave, one clock at 20 MHz
// Notes:   ch1 is a one-cycle enable at the divided rate; ch0 is too only with source SCDS_SRC_DIV, else it follows its selected tick input
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module scds_top
(
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // Avalon-MM slave
    input  wire logic [scds_pkg::SCDS_ADDR_W-1:0] address,
    input  wire logic                          read,
    input  wire logic                          write,
    input  wire logic [scds_pkg::SCDS_DATA_W-1:0] writedata,
    input  wire logic [3:0]                    byteenable,
    output logic [scds_pkg::SCDS_DATA_W-1:0]   readdata,
    output logic                               waitrequest,
    // Channel inputs
    input  wire logic                          ch0_ext_tick,
    input  wire logic                          ch0_timer_tick,
    // Channel clock enables
    output logic                               ch0_clk_en,
    output logic                               ch1_clk_en
);
    import scds_pkg::*;

    typedef struct packed
    {
        scds_bus_t               bus;
        logic [7:0]              sel;
        logic                    osc_full;
        logic [1:0]              src;
        logic [SCDS_DATA_W-1:0]  rdata;
        logic                    ch0;
        logic                    ch1;
        logic                    wreq;
    } scds_st_t;

    scds_st_t   st_r;
    scds_st_t   st_nxt;
    logic [1:0] tick;

    scds_divider
    #(
        .PRE_W    (SCDS_PRE_W)
    )
    u_div
    (
        .clk      (clk),
        .rst      (rst),
        .osc_full (st_r.osc_full),
        .sel      (st_r.sel),
        .tick     (tick)
    );

    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.ch1   = tick[1];
        // Channel 0 source mux
        case (st_r.src)
            SCDS_SRC_DIV:   st_nxt.ch0 = tick[0];
            SCDS_SRC_TIMER: st_nxt.ch0 = ch0_timer_tick;
            default:        st_nxt.ch0 = ch0_ext_tick;
        endcase
        case (st_r.bus)
            SCDS_IDLE:
            begin
                if ((read || write) && address[1:0] == 2'b00)
                begin
                    st_nxt.bus   = SCDS_ACK;
                    st_nxt.rdata = '0;
                end
                else if (read || write)
                    st_nxt.bus = SCDS_ACK;
            end
            SCDS_ACK:
                st_nxt.bus = SCDS_IDLE;
            default:
                st_nxt.bus = SCDS_IDLE;
        endcase
        // Registers at word-aligned byte addresses holding each printed offset
        if (st_r.bus == SCDS_IDLE && (read || write))
        begin
            st_nxt.rdata = '0;
            if ({address[15:2], 2'b00} == {SCDS_SEL_OFFSET[15:2], 2'b00})
            begin
                st_nxt.rdata[7:0] = st_r.sel;
                if (write && byteenable[SCDS_SEL_OFFSET[1:0]])
                    st_nxt.sel = writedata[8*SCDS_SEL_OFFSET[1:0] +: 8];
                else
                    st_nxt.sel = st_r.sel;
                st_nxt.rdata = {24'h00_0000, st_r.sel} << (8*SCDS_SEL_OFFSET[1:0]);
            end
            else if ({address[15:2], 2'b00} == SCDS_OSC_OFFSET)
            begin
                st_nxt.rdata[SCDS_OSC_BIT] = st_r.osc_full;
                if (write && byteenable[0])
                    st_nxt.osc_full = writedata[SCDS_OSC_BIT];
            end
            else if ({address[15:2], 2'b00} == SCDS_SRC_OFFSET)
            begin
                st_nxt.rdata[1:0] = st_r.src;
                if (write && byteenable[0])
                    st_nxt.src = writedata[1:0];
            end
            else
            begin
                st_nxt.sel = st_r.sel;
            end
        end
        // Wait is low only in the answer cycle, so it can come from a flop
        st_nxt.wreq = (st_nxt.bus != SCDS_ACK);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r          <= '0;
            st_r.wreq     <= 1'b1;
            st_r.bus      <= SCDS_IDLE;
            st_r.sel      <= SCDS_SEL_RESET;
            st_r.osc_full <= SCDS_OSC_RESET;
            st_r.src      <= SCDS_SRC_RESET;
        end
        else
            st_r <= st_nxt;
    end

    // Request held until acknowledged one cycle later
    assign waitrequest = st_r.wreq;
    assign readdata    = st_r.rdata;
    assign ch0_clk_en  = st_r.ch0;
    assign ch1_clk_en  = st_r.ch1;
endmodule
`default_nettype wire

// ==== verification/scds_checker.sv ====
// Purpose: Port checks for the serial clock divider select block
// Assumes: Register values shadowed from accepted bus writes
// Notes:   Periods judged from the third enable after any write
`timescale 1ns/1ps
`default_nettype none
module scds_checker
(
    // Clock, reset and bus
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [15:0] address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // Channel enables
    input wire logic        ch0_clk_en,
    input wire logic        ch1_clk_en
);
    logic [7:0] sel_r;
    logic       osc_r;
    logic [1:0] src_r;
    logic [9:0] gap_r [2];
    logic [1:0] seen_r [2];
    wire        wr_acc = write & ~waitrequest;
    wire        rd_acc = read & ~waitrequest;
    wire  [1:0] en     = {ch1_clk_en, ch0_clk_en};
    function automatic logic [9:0] per(input logic [3:0] c);
        return (c < 4'h6 || c > 4'hd) ? 10'h000 : 10'h001 << (c - (osc_r ? 4'h5 : 4'h4));
    endfunction
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            sel_r <= 8'h88;
            osc_r <= 1'b0;
            src_r <= 2'h0;
            gap_r <= '{default: 10'h000};
            seen_r <= '{default: 2'h0};
        end
        else
        begin
            if (wr_acc && address == 16'hff40) sel_r <= writedata[31:24];
            if (wr_acc && address == 16'hff44) osc_r <= writedata[0];
            if (wr_acc && address == 16'hff48) src_r <= writedata[1:0];
            for (int i = 0; i < 2; i++)
            begin
                gap_r[i] <= en[i] ? 10'h001 : gap_r[i] + 10'h001;
                if (wr_acc) seen_r[i] <= 2'h0;
                else if (en[i] && seen_r[i] != 2'h3) seen_r[i] <= seen_r[i] + 2'h1;
            end
        end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_wait_first: assert property ($rose(read | write) |-> waitrequest) else $error("no wait cycle");
    a_wait_second: assert property ($rose(read | write) |=> !waitrequest) else $error("late answer");
    a_sel_readback: assert property (rd_acc && address == 16'hff40 |-> readdata[31:24] == sel_r)
        else $error("select readback");
    a_osc_readback: assert property (rd_acc && address == 16'hff44 |-> readdata[0] == osc_r)
        else $error("mode readback");
    a_unmapped_zero: assert property (rd_acc && !(address inside {16'hff40, 16'hff44, 16'hff48}) |-> readdata == 0)
        else $error("unmapped read");
    a_ch0_period: assert property (ch0_clk_en && seen_r[0] > 2'h1 && src_r == 2'h3 && per(sel_r[3:0]) != 0
        |-> gap_r[0] == per(sel_r[3:0])) else $error("ch0 period");
    a_ch1_period: assert property (ch1_clk_en && seen_r[1] > 2'h1 && per(sel_r[7:4]) != 0
        |-> gap_r[1] == per(sel_r[7:4])) else $error("ch1 period");
    a_ch1_single: assert property (ch1_clk_en |=> !ch1_clk_en) else $error("ch1 enable too long");
endmodule
`default_nettype wire

// ==== verification/scds_top_tb.sv ====
// Purpose: Self-checking bench for the serial clock divider select block
// Assumes: One wait cycle per bus access, 20 MHz clock
// Notes:   Enable periods counted in clock cycles
`timescale 1ns/1ps
`default_nettype none
module scds_top_tb;
    import scds_pkg::*;
    logic        clk = 0, rst = 1, read = 0, write = 0, ext = 0, tmr = 0, waitrequest, en0, en1;
    logic [15:0] address = 0;
    logic [31:0] writedata = 0, readdata, q;
    logic [3:0]  byteenable = 4'hf;
    int          error_cnt = 0, checks_done = 0;
    scds_top scds_top_i (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .ch0_ext_tick(ext), .ch0_timer_tick(tmr), .ch0_clk_en(en0), .ch1_clk_en(en1));
    initial forever #25 clk = ~clk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 0;
        write <= 0;
    endtask
    task automatic per(input logic ch, input int e);
        int n;
        n = 0;
        repeat (2) do @(negedge clk); while ((ch ? en1 : en0) !== 1'b1);
        do
        begin
            @(negedge clk);
            n++;
        end
        while ((ch ? en1 : en0) !== 1'b1);
        chk(ch ? "ch1 period" : "ch0 period", e, n);
    endtask
    task automatic t_regs();
        bus(0, 16'hff40, 0);
        chk("sel reset", 8'h88, q[31:24]);
        bus(0, 16'hff44, 0);
        chk("mode reset", 0, q[0]);
        bus(1, 16'hff4c, 32'hffff_ffff);
        bus(0, 16'hff4c, 0);
        chk("unmapped", 0, q);
        bus(1, 16'hff40, 32'h3f00_0000);
        bus(0, 16'hff40, 0);
        chk("prohibited kept", 8'h3f, q[31:24]);
    endtask
    task automatic t_rates();
        bus(1, 16'hff48, 32'h0000_0003);
        for (int o = 0; o < 2; o++)
        begin
            bus(1, 16'hff44, o);
            for (int c = 6 + o; c < 14; c++)
            begin
                bus(1, 16'hff40, {c[3:0], c[3:0], 24'h00_0000});
                per(0, 1 << (c - 4 - o));
                per(1, 1 << (c - 4 - o));
            end
        end
    endtask
    task automatic t_src(input logic [1:0] s);
        int n;
        n = 0;
        bus(1, 16'hff48, {30'h0, s});
        for (int i = 0; i < 40; i++)
        begin
            @(posedge clk);
            ext <= i % (s[1] ? 3 : 8) == 0 && i < 32;
            tmr <= i % (s[1] ? 8 : 3) == 0 && i < 32;
            @(negedge clk);
            n += en0;
        end
        chk("ch0 source", 4, n);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 0;
        t_regs();
        t_rates();
        for (int s = 0; s < 3; s++) t_src(s[1:0]);
        print_verdict();
    end
    initial
    begin
        #(40000 * 50);
        error_cnt++;
        print_verdict();
    end
endmodule
bind scds_top scds_checker scds_checker_i (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .ch0_clk_en(ch0_clk_en),
    .ch1_clk_en(ch1_clk_en));
`default_nettype wire
